/* File: rtl/dlea_pkg.sv */
// Contract
// (R1) Data byte register carries memory contents both ways.
// (R2) Sixteen-bit memory address held in two byte registers.
// (R3) Status shows write lock, read lock, security error.
// (R4) Status bits five to one read zero.
// (R5) Block check low write starts 256-byte CRC.
// (R6) Written byte is upper start address byte.
// (R7) Lower start address byte is always zero.
// (R8) Result high byte one, low byte zero.
// (R9) Link target select routes data commands.
// (R10) Link status bit seven shows operation busy.
// (R11) Locks follow address; error updated per access.
package dlea_pkg;

  // Link target select codes.
  localparam logic [7:0] TGT_DATA    = 8'hBF;
  localparam logic [7:0] TGT_STATUS  = 8'hB7;
  localparam logic [7:0] TGT_ADDR_HI = 8'hAF;
  localparam logic [7:0] TGT_ADDR_LO = 8'hAE;
  localparam logic [7:0] TGT_BLOCK_CHECK_LOW_BYTE    = 8'hA9;
  localparam logic [7:0] TGT_BLOCK_CHECK_BYTE_ONE    = 8'hAA;

  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [4:0] STAT_UNUSED = 5'h00;
  localparam logic [6:0] LINK_STAT_Z = 7'h00;
  localparam int         BUSY_BIT    = 7;

  // Memory geometry and block check.
  localparam int          MEM_AW      = 14;
  localparam int          MEM_DEPTH   = 16384;
  localparam logic [7:0]  BLOCK_LOW   = 8'h00;
  localparam logic [8:0]  BLOCK_LAST  = 9'h100;
  localparam logic [8:0]  CNT_ZERO    = 9'h000;
  localparam logic [8:0]  CNT_ONE     = 9'h001;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] CRC_INIT    = 16'h0000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_MRD  = 4'h2,
    ST_MCAP = 4'h4,
    ST_CRC  = 4'h8
  } dlea_state_e;

  // A page below its limit is protected.
  function automatic logic page_locked(input logic [7:0] page, input logic [7:0] limit);
    page_locked = (page < limit);
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] acc, input logic [7:0] din);
    logic [15:0] c;
    c = acc ^ {din, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    crc_step = c;
  endfunction

endpackage

/* File: rtl/dlea_mem_if.sv */
`timescale 1ns/1ps
interface dlea_mem_if;
  logic        rd_en;
  logic        wr_en;
  logic [13:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  modport ctrl (output rd_en, output wr_en, output addr, output wdata, input rdata);
  modport mem  (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface

/* File: rtl/dlea_mem.sv */
`timescale 1ns/1ps
module dlea_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Access port
  dlea_mem_if.mem  bus
);

  logic [7:0] mem_array [dlea_pkg::MEM_DEPTH];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = bus.rd_en ? mem_array[bus.addr] : rdata_reg;
  end

  // The array itself has no reset, so it maps onto a plain RAM.
  always_ff @(posedge clk) begin
    if (bus.wr_en) begin
      mem_array[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= dlea_pkg::RST_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus.rdata = rdata_reg;

endmodule // dlea_mem

/* File: rtl/dlea_top.sv */
`timescale 1ns/1ps
module dlea_top (
  // Core clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Two-wire debug link side
  input  wire logic       link_clk,
  input  wire logic       lk_addr_wr,
  input  wire logic       lk_data_wr,
  input  wire logic       lk_data_rd,
  input  wire logic       lk_stat_rd,
  input  wire logic [7:0] lk_wdata,
  output logic      [7:0] lk_rdata,
  output logic            lk_rvalid,
  // Security limits from the core domain
  input  wire logic [7:0] wr_lock_page,
  input  wire logic [7:0] rd_lock_page
);

  // Link domain.
  logic [7:0] tgt_reg, tgt_next;
  logic       busy_reg, busy_next;
  logic       req_tog_reg, req_tog_next;
  logic       req_wr_reg, req_wr_next;
  logic [7:0] req_tgt_reg, req_tgt_next;
  logic [7:0] req_data_reg, req_data_next;
  logic       ack_s1_reg, ack_s2_reg, ack_seen_reg, ack_seen_next;
  logic [7:0] lk_rdata_reg, lk_rdata_next;
  logic       lk_rvalid_reg, lk_rvalid_next;
  logic       ack_new;
  logic       ack_tog_reg;
  logic [7:0] core_out_reg;
  assign ack_new = ack_s2_reg != ack_seen_reg;
  always_comb begin
    tgt_next       = tgt_reg;
    busy_next      = busy_reg;
    req_tog_next   = req_tog_reg;
    req_wr_next    = req_wr_reg;
    req_tgt_next   = req_tgt_reg;
    req_data_next  = req_data_reg;
    ack_seen_next  = ack_seen_reg;
    lk_rdata_next  = lk_rdata_reg;
    lk_rvalid_next = 1'b0;
    if (lk_addr_wr) begin
      tgt_next = lk_wdata; // R9
    end
    if (lk_stat_rd) begin
      lk_rdata_next  = {busy_reg, dlea_pkg::LINK_STAT_Z}; // R10
      lk_rvalid_next = 1'b1;
    end
    if (ack_new) begin
      ack_seen_next = ack_s2_reg;
      busy_next     = 1'b0; // R10
      // The core holds its answer until the next request, so it is stable here.
      if (!req_wr_reg) begin
        lk_rdata_next  = core_out_reg;
        lk_rvalid_next = 1'b1;
      end
    end else if ((lk_data_wr || lk_data_rd) && !busy_reg) begin
      req_tog_next  = ~req_tog_reg;
      req_wr_next   = lk_data_wr;
      req_tgt_next  = tgt_reg; // R9
      req_data_next = lk_wdata;
      busy_next     = 1'b1; // R10
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      tgt_reg       <= dlea_pkg::RST_BYTE;
      busy_reg      <= 1'b0;
      req_tog_reg   <= 1'b0;
      req_wr_reg    <= 1'b0;
      req_tgt_reg   <= dlea_pkg::RST_BYTE;
      req_data_reg  <= dlea_pkg::RST_BYTE;
      ack_s1_reg    <= 1'b0;
      ack_s2_reg    <= 1'b0;
      ack_seen_reg  <= 1'b0;
      lk_rdata_reg  <= dlea_pkg::RST_BYTE;
      lk_rvalid_reg <= 1'b0;
    end else begin
      tgt_reg       <= tgt_next;
      busy_reg      <= busy_next;
      req_tog_reg   <= req_tog_next;
      req_wr_reg    <= req_wr_next;
      req_tgt_reg   <= req_tgt_next;
      req_data_reg  <= req_data_next;
      ack_s1_reg    <= ack_tog_reg;
      ack_s2_reg    <= ack_s1_reg;
      ack_seen_reg  <= ack_seen_next;
      lk_rdata_reg  <= lk_rdata_next;
      lk_rvalid_reg <= lk_rvalid_next;
    end
  end

  assign lk_rdata  = lk_rdata_reg;
  assign lk_rvalid = lk_rvalid_reg;
  addr_sel_a: assert property (@(posedge link_clk) disable iff (!rst_b) // R9
    lk_addr_wr |=> tgt_reg == $past(lk_wdata))
    else $error("target select not loaded");
  busy_set_a: assert property (@(posedge link_clk) disable iff (!rst_b) // R10
    (lk_data_wr && !busy_reg && !ack_new) |=> busy_reg && req_tgt_reg == $past(tgt_reg))
    else $error("busy not raised on data command");
  stat_poll_a: assert property (@(posedge link_clk) disable iff (!rst_b) // R10
    (lk_stat_rd && !ack_new) |=> lk_rvalid && lk_rdata[dlea_pkg::BUSY_BIT] == $past(busy_reg))
    else $error("status poll busy bit wrong");

  // Core domain.
  dlea_mem_if mem_bus ();
  dlea_mem u_mem (
    .clk   (clk),
    .rst_b (rst_b),
    .bus   (mem_bus)
  );

  dlea_pkg::dlea_state_e state_reg, state_next;
  logic        req_s1_reg, req_s2_reg, req_seen_reg, req_seen_next;
  logic        ack_tog_next;
  logic [7:0]  addr_hi_reg, addr_hi_next, addr_lo_reg, addr_lo_next;
  logic [7:0]  data_reg, data_next;
  logic [7:0]  block_check_low_byte_reg, block_check_low_byte_next, block_check_byte_one_reg, block_check_byte_one_next;
  logic        err_reg, err_next;
  logic [7:0]  core_out_next;
  logic [7:0]  crc_base_reg, crc_base_next;
  logic [8:0]  cnt_reg, cnt_next;
  logic [15:0] crc_acc_reg, crc_acc_next;
  logic [15:0] crc_final, mem_addr_full, crc_addr_full;
  logic        req_new, wr_lk, rd_lk;
  logic [7:0]  status_val;
  assign req_new    = (req_s2_reg != req_seen_reg) && (state_reg == dlea_pkg::ST_IDLE);
  assign wr_lk      = dlea_pkg::page_locked(addr_hi_reg, wr_lock_page); // R11
  assign rd_lk      = dlea_pkg::page_locked(addr_hi_reg, rd_lock_page); // R11
  assign status_val = {wr_lk, rd_lk, dlea_pkg::STAT_UNUSED, err_reg}; // R3 R4
  assign crc_final  = dlea_pkg::crc_step(crc_acc_reg, mem_bus.rdata);
  // The top address bits lie beyond the memory and are dropped on purpose below.
  assign mem_addr_full = {addr_hi_reg, addr_lo_reg}; // R2
  assign crc_addr_full = {crc_base_reg, cnt_reg[7:0]}; // R6 R7
  always_comb begin
    mem_bus.rd_en = 1'b0;
    mem_bus.wr_en = 1'b0;
    mem_bus.addr  = mem_addr_full[dlea_pkg::MEM_AW-1:0]; // R2
    mem_bus.wdata = req_data_reg;
    if (state_reg == dlea_pkg::ST_CRC) begin
      mem_bus.rd_en = cnt_reg != dlea_pkg::BLOCK_LAST; // R5
      mem_bus.addr  = crc_addr_full[dlea_pkg::MEM_AW-1:0]; // R6 R7
    end else if (state_reg == dlea_pkg::ST_MRD) begin
      mem_bus.rd_en = 1'b1;
    end else if (req_new && req_wr_reg && req_tgt_reg == dlea_pkg::TGT_DATA && !wr_lk) begin
      mem_bus.wr_en = 1'b1; // R1
    end
  end

  always_comb begin
    state_next    = state_reg;
    req_seen_next = req_seen_reg;
    ack_tog_next  = ack_tog_reg;
    addr_hi_next  = addr_hi_reg;
    addr_lo_next  = addr_lo_reg;
    data_next     = data_reg;
    block_check_low_byte_next     = block_check_low_byte_reg;
    block_check_byte_one_next     = block_check_byte_one_reg;
    err_next      = err_reg;
    core_out_next = core_out_reg;
    crc_base_next = crc_base_reg;
    cnt_next      = cnt_reg;
    crc_acc_next  = crc_acc_reg;
    case (state_reg)
      dlea_pkg::ST_IDLE: begin
        if (req_new) begin
          req_seen_next = req_s2_reg;
          ack_tog_next  = ~ack_tog_reg;
          if (req_wr_reg) begin
            case (req_tgt_reg)
              dlea_pkg::TGT_ADDR_HI: addr_hi_next = req_data_reg; // R2
              dlea_pkg::TGT_ADDR_LO: addr_lo_next = req_data_reg; // R2
              dlea_pkg::TGT_DATA: begin
                err_next = wr_lk; // R3 R11
                if (!wr_lk) begin
                  data_next = req_data_reg; // R1
                end
              end
              dlea_pkg::TGT_BLOCK_CHECK_LOW_BYTE: begin
                // The answer is held back until the block check ends, keeping the link busy.
                ack_tog_next  = ack_tog_reg;
                crc_base_next = req_data_reg; // R6
                cnt_next      = dlea_pkg::CNT_ZERO;
                crc_acc_next  = dlea_pkg::CRC_INIT;
                state_next    = dlea_pkg::ST_CRC; // R5
              end
              default: ;
            endcase
          end else begin
            case (req_tgt_reg)
              dlea_pkg::TGT_DATA: begin
                if (rd_lk) begin
                  err_next      = 1'b1; // R3 R11
                  core_out_next = data_reg;
                end else begin
                  ack_tog_next = ack_tog_reg;
                  state_next   = dlea_pkg::ST_MRD;
                end
              end
              dlea_pkg::TGT_STATUS:  core_out_next = status_val; // R3 R4
              dlea_pkg::TGT_ADDR_HI: core_out_next = addr_hi_reg;
              dlea_pkg::TGT_ADDR_LO: core_out_next = addr_lo_reg;
              dlea_pkg::TGT_BLOCK_CHECK_LOW_BYTE:    core_out_next = block_check_low_byte_reg;
              dlea_pkg::TGT_BLOCK_CHECK_BYTE_ONE:    core_out_next = block_check_byte_one_reg;
              default:               core_out_next = dlea_pkg::RST_BYTE;
            endcase
          end
        end
      end
      dlea_pkg::ST_MRD: state_next = dlea_pkg::ST_MCAP;
      dlea_pkg::ST_MCAP: begin
        data_next     = mem_bus.rdata; // R1
        core_out_next = mem_bus.rdata;
        err_next      = 1'b0; // R11
        ack_tog_next  = ~ack_tog_reg;
        state_next    = dlea_pkg::ST_IDLE;
      end
      dlea_pkg::ST_CRC: begin
        cnt_next = cnt_reg + dlea_pkg::CNT_ONE;
        if (cnt_reg != dlea_pkg::CNT_ZERO) begin
          crc_acc_next = crc_final;
        end
        if (cnt_reg == dlea_pkg::BLOCK_LAST) begin
          block_check_byte_one_next    = crc_final[15:8]; // R8
          block_check_low_byte_next    = crc_final[7:0]; // R8
          ack_tog_next = ~ack_tog_reg;
          state_next   = dlea_pkg::ST_IDLE;
        end
      end
      default: state_next = dlea_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= dlea_pkg::ST_IDLE;
      req_s1_reg   <= 1'b0;
      req_s2_reg   <= 1'b0;
      req_seen_reg <= 1'b0;
      ack_tog_reg  <= 1'b0;
      addr_hi_reg  <= dlea_pkg::RST_BYTE;
      addr_lo_reg  <= dlea_pkg::RST_BYTE;
      data_reg     <= dlea_pkg::RST_BYTE;
      block_check_low_byte_reg     <= dlea_pkg::RST_BYTE;
      block_check_byte_one_reg     <= dlea_pkg::RST_BYTE;
      err_reg      <= 1'b0;
      core_out_reg <= dlea_pkg::RST_BYTE;
      crc_base_reg <= dlea_pkg::RST_BYTE;
      cnt_reg      <= dlea_pkg::CNT_ZERO;
      crc_acc_reg  <= dlea_pkg::CRC_INIT;
    end else begin
      state_reg    <= state_next;
      req_s1_reg   <= req_tog_reg;
      req_s2_reg   <= req_s1_reg;
      req_seen_reg <= req_seen_next;
      ack_tog_reg  <= ack_tog_next;
      addr_hi_reg  <= addr_hi_next;
      addr_lo_reg  <= addr_lo_next;
      data_reg     <= data_next;
      block_check_low_byte_reg     <= block_check_low_byte_next;
      block_check_byte_one_reg     <= block_check_byte_one_next;
      err_reg      <= err_next;
      core_out_reg <= core_out_next;
      crc_base_reg <= crc_base_next;
      cnt_reg      <= cnt_next;
      crc_acc_reg  <= crc_acc_next;
    end
  end

  sequence s_crc_start;
    req_new && req_wr_reg && req_tgt_reg == dlea_pkg::TGT_BLOCK_CHECK_LOW_BYTE;
  endsequence
  sequence s_mem_read;
    req_new && !req_wr_reg && req_tgt_reg == dlea_pkg::TGT_DATA && !rd_lk;
  endsequence
  crc_start_a: assert property (@(posedge clk) disable iff (!rst_b) // R6 R7
    s_crc_start |=> crc_base_reg == $past(req_data_reg) && mem_bus.addr[7:0] == dlea_pkg::BLOCK_LOW)
    else $error("block check start address wrong");
  crc_len_a: assert property (@(posedge clk) disable iff (!rst_b) // R5
    s_crc_start |-> ##257 state_reg == dlea_pkg::ST_CRC ##1 state_reg == dlea_pkg::ST_IDLE)
    else $error("block check length not 256 bytes");
  crc_result_a: assert property (@(posedge clk) disable iff (!rst_b) // R8
    (state_reg == dlea_pkg::ST_CRC && cnt_reg == dlea_pkg::BLOCK_LAST)
      |=> block_check_byte_one_reg == $past(crc_final[15:8]) && block_check_low_byte_reg == $past(crc_final[7:0]) && ack_tog_reg != $past(ack_tog_reg))
    else $error("block check result misplaced");
  stat_read_a: assert property (@(posedge clk) disable iff (!rst_b) // R3 R4
    (req_new && !req_wr_reg && req_tgt_reg == dlea_pkg::TGT_STATUS)
      |=> core_out_reg[5:1] == dlea_pkg::STAT_UNUSED
          && core_out_reg[7] == $past(wr_lk) && core_out_reg[6] == $past(rd_lk))
    else $error("status read wrong");
  wr_lock_a: assert property (@(posedge clk) disable iff (!rst_b) // R3
    (req_new && req_wr_reg && req_tgt_reg == dlea_pkg::TGT_DATA && wr_lk) |-> !mem_bus.wr_en ##1 err_reg)
    else $error("locked write not refused");
  mem_read_a: assert property (@(posedge clk) disable iff (!rst_b) // R1
    s_mem_read |=> mem_bus.rd_en ##1 state_reg == dlea_pkg::ST_MCAP ##1 data_reg == $past(mem_bus.rdata) && !err_reg)
    else $error("memory read not captured");

endmodule // dlea_top

/* File: testbench/dlea_tool_model.sv */
`timescale 1ns/1ps
module dlea_tool_model (
  // Link clock made by the tool
  output logic            link_clk,
  // Command strobes and data
  output logic            lk_addr_wr,
  output logic            lk_data_wr,
  output logic            lk_data_rd,
  output logic            lk_stat_rd,
  output logic      [7:0] lk_wdata,
  // Answers from the device
  input  wire logic [7:0] lk_rdata,
  input  wire logic       lk_rvalid
);
  initial begin
    link_clk = 1'b0;
    {lk_addr_wr, lk_data_wr, lk_data_rd, lk_stat_rd} = 4'h0;
    lk_wdata = 8'h00;
  end
  always #7.5 link_clk = ~link_clk;

  // Kind 0 selects a target, 1 writes, 2 reads, 3 polls. Idle data lines carry the inverse
  // of the last byte, so the device can never lean on a stale value.
  task automatic pulse(input logic [1:0] k, input logic [7:0] d);
    @(negedge link_clk);
    {lk_addr_wr, lk_data_wr, lk_data_rd, lk_stat_rd} <= 4'h8 >> k;
    lk_wdata <= d;
    @(negedge link_clk);
    {lk_addr_wr, lk_data_wr, lk_data_rd, lk_stat_rd} <= 4'h0;
    lk_wdata <= ~d;
  endtask

  // The strobe is looked at before waiting, as a status answer may already stand.
  task automatic answer(output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 60 && !ok; i++) begin
      if (lk_rvalid === 1'b1) begin
        ok = 1'b1;
        d = lk_rdata;
      end else begin
        @(negedge link_clk);
      end
    end
  endtask

  task automatic wait_idle(output logic ok);
    logic [7:0] s;
    logic       got;
    ok = 1'b0;
    // A block check keeps the link busy for close to 900 link cycles, two per poll.
    for (int i = 0; i < 1000 && !ok; i++) begin
      pulse(2'd3, 8'h00);
      answer(s, got);
      ok = got && s[7] === 1'b0;
    end
  endtask
endmodule // dlea_tool_model

/* File: testbench/debug_link_eprom_access_regs_tb.sv */
`timescale 1ns/1ps
module debug_link_eprom_access_regs_tb;
  logic       clk, rst_b, link_clk, lk_rvalid;
  logic       lk_addr_wr, lk_data_wr, lk_data_rd, lk_stat_rd;
  logic [7:0] lk_wdata, lk_rdata, wr_lock_page, rd_lock_page;
  int         mismatches;
  int         checks;

  dlea_top uut (.clk, .rst_b, .link_clk, .lk_addr_wr, .lk_data_wr, .lk_data_rd, .lk_stat_rd,
                .lk_wdata, .lk_rdata, .lk_rvalid, .wr_lock_page, .rd_lock_page);
  dlea_tool_model tool (.link_clk, .lk_addr_wr, .lk_data_wr, .lk_data_rd, .lk_stat_rd,
                        .lk_wdata, .lk_rdata, .lk_rvalid);

  always #25 clk = ~clk;

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: read %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic stalled(input logic ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: no answer on the link", $time);
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] t, input logic [7:0] d);
    logic ok;
    tool.pulse(2'd0, t);
    tool.pulse(2'd1, d);
    tool.wait_idle(ok);
    stalled(ok);
  endtask

  task automatic rd(input logic [7:0] t, output logic [7:0] d);
    logic ok;
    tool.pulse(2'd0, t);
    tool.pulse(2'd2, 8'h00);
    tool.answer(d, ok);
    stalled(ok);
    tool.wait_idle(ok);
    stalled(ok);
  endtask

  task automatic rd_check(input logic [7:0] t, input logic [7:0] e);
    logic [7:0] d;
    rd(t, d);
    check(d, e);
  endtask

  task automatic set_addr(input logic [15:0] a);
    wr(8'hAF, a[15:8]);
    wr(8'hAE, a[7:0]);
  endtask

  // Page 4 is locked both ways, page 9 for writes only, page 0x20 not at all.
  task automatic test_locks();
    logic [7:0] d;
    rd_check(8'hAF, 8'h00);
    rd_check(8'hAE, 8'h00);
    rd_check(8'hA9, 8'h00);
    rd_check(8'hAA, 8'h00);
    set_addr(16'h0405);
    rd_check(8'hBF, 8'h00);
    rd_check(8'hB7, 8'hC1);
    wr(8'hB7, 8'hFF);
    rd_check(8'hB7, 8'hC1);
    set_addr(16'h0905);
    rd_check(8'hB7, 8'h81);
    rd(8'hBF, d);
    rd_check(8'hB7, 8'h80);
    wr(8'hBF, 8'h77);
    rd_check(8'hB7, 8'h81);
    set_addr(16'h2005);
    rd_check(8'hB7, 8'h01);
    $display("test_locks done");
  endtask

  task automatic test_data();
    set_addr(16'h215A);
    wr(8'hBF, 8'hC3);
    set_addr(16'h215B);
    wr(8'hBF, 8'h3C);
    rd_check(8'hAF, 8'h21);
    rd_check(8'hAE, 8'h5B);
    rd_check(8'hB7, 8'h00);
    wr(8'h55, 8'hEE);
    rd_check(8'h55, 8'h00);
    set_addr(16'h215A);
    rd_check(8'hBF, 8'hC3);
    $display("test_data done");
  endtask

  // A write sent while the read is still busy must be dropped.
  task automatic test_busy();
    logic [7:0] d;
    logic       ok;
    tool.pulse(2'd0, 8'hBF);
    tool.pulse(2'd2, 8'h00);
    tool.pulse(2'd1, 8'hEE);
    tool.pulse(2'd3, 8'h00);
    tool.answer(d, ok);
    stalled(ok);
    check(d, 8'h80);
    @(negedge link_clk);
    tool.answer(d, ok);
    stalled(ok);
    check(d, 8'hC3);
    tool.wait_idle(ok);
    stalled(ok);
    rd_check(8'hBF, 8'hC3);
    $display("test_busy done");
  endtask

  // Byte 0x2300, page 0x21 and the low address byte 0x80 must all stay out of the sum.
  task automatic test_crc();
    logic [15:0] crc;
    logic [7:0]  b;
    crc = dlea_pkg::CRC_INIT;
    set_addr(16'h2300);
    wr(8'hBF, 8'hA5);
    wr(8'hAF, 8'h22);
    for (int i = 0; i < 256; i++) begin
      b = 8'(i * 37 + 11);
      wr(8'hAE, 8'(i));
      wr(8'hBF, b);
      crc = crc ^ {b, 8'h00};
      for (int j = 0; j < 8; j++) begin
        crc = crc[15] ? ((crc << 1) ^ dlea_pkg::CRC_POLY) : (crc << 1);
      end
    end
    set_addr(16'h2180);
    wr(8'hA9, 8'h22);
    rd_check(8'hAA, crc[15:8]);
    rd_check(8'hA9, crc[7:0]);
    $display("test_crc done");
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    wr_lock_page = 8'h10;
    rd_lock_page = 8'h08;
    mismatches = 0;
    checks = 0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    test_locks();
    test_data();
    test_busy();
    test_crc();
    complete_run();
  end
endmodule // debug_link_eprom_access_regs_tb
